// ### hssdc_load_model.sv
// Behavioural load on the switch output that measures on-time and period
`timescale 1ns/10ps

module hssdc_load_model (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic switch_on_i,
  output int        on_len_o,
  output int        period_o,
  output int        rises_o
);
  int   on_cnt;
  int   per_cnt;
  logic last_q;

  // Figures of the period just ended are latched at each turn-on edge
  always_ff @(posedge clk_i) begin
    last_q <= switch_on_i;
    if (srst_i) begin
      rises_o <= 0;
      on_cnt  <= 0;
      per_cnt <= 0;
    end else if (switch_on_i && !last_q) begin
      on_len_o <= on_cnt;
      period_o <= per_cnt;
      rises_o  <= rises_o + 1;
      on_cnt   <= 1;
      per_cnt  <= 1;
    end else begin
      on_cnt  <= on_cnt + (switch_on_i ? 1 : 0);
      per_cnt <= per_cnt + 1;
    end
  end
endmodule

// ### hssdc_pkg.sv
// Constants for the high-side switch drive control block
package hssdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (7-bit register addresses)
  localparam logic [6:0] ADDR_SWITCH_CONTROL      = 7'h1E;
  localparam logic [6:0] ADDR_DUTY_GEN_A_RATE     = 7'h1F;
  localparam logic [6:0] ADDR_DUTY_GEN_A_DUTY_HI  = 7'h20;
  localparam logic [6:0] ADDR_DUTY_GEN_A_DUTY_LO  = 7'h21;
  localparam logic [6:0] ADDR_DUTY_GEN_B_RATE     = 7'h22;
  localparam logic [6:0] ADDR_DUTY_GEN_B_DUTY_HI  = 7'h23;
  localparam logic [6:0] ADDR_DUTY_GEN_B_DUTY_LO  = 7'h24;
  localparam logic [6:0] ADDR_PULSE_TIMER_A_CFG   = 7'h25;
  localparam logic [6:0] ADDR_PULSE_TIMER_B_CFG   = 7'h26;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int SW_ENABLE_BIT     = 7;
  localparam int SW_SOURCE_LSB     = 4;
  localparam int RATE_BIT          = 7;
  localparam int TIMER_WIDTH_LSB   = 4;
  localparam int TIMER_PERIOD_LSB  = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Source select codes
  localparam logic [2:0] SRC_ON_OFF      = 3'h0;
  localparam logic [2:0] SRC_DUTY_GEN_A  = 3'h1;
  localparam logic [2:0] SRC_DUTY_GEN_B  = 3'h2;
  localparam logic [2:0] SRC_TIMER_A     = 3'h3;
  localparam logic [2:0] SRC_TIMER_B     = 3'h4;
  localparam logic [2:0] SRC_EXTRA       = 3'h5;

  // Timer on-width extremes
  localparam logic [3:0] WIDTH_OFF       = 4'h0;
  localparam logic [3:0] WIDTH_FULL      = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int PWM_RATE_LO_HZ  = 200;
  localparam int PWM_RATE_HI_HZ  = 400;
  localparam int PWM_STEPS       = 1024;
  // Cycles per duty step; truncation makes the rate a hair fast (under 0.1%)
  localparam int PWM_PRESC_LO    = CLK_HZ / (PWM_RATE_LO_HZ * PWM_STEPS);
  localparam int PWM_PRESC_HI    = CLK_HZ / (PWM_RATE_HI_HZ * PWM_STEPS);
  localparam int TIMER_TICK_US   = 10;
  localparam int TIMER_TICK_CYC  = CLK_HZ / 1_000_000 * TIMER_TICK_US;

  // On-width in 10 us ticks
  function automatic logic [17:0] hssdc_width_ticks(input logic [3:0] code);
    case (code)
      4'h1:    hssdc_width_ticks = 18'h0000A;   // 0.1 ms
      4'h2:    hssdc_width_ticks = 18'h0001E;   // 0.3 ms
      4'h3:    hssdc_width_ticks = 18'h00032;   // 0.5 ms
      4'h4:    hssdc_width_ticks = 18'h00064;   // 1 ms
      4'h5:    hssdc_width_ticks = 18'h003E8;   // 10 ms
      4'h6:    hssdc_width_ticks = 18'h007D0;   // 20 ms
      4'h7:    hssdc_width_ticks = 18'h00BB8;   // 30 ms
      4'h8:    hssdc_width_ticks = 18'h00FA0;   // 40 ms
      4'h9:    hssdc_width_ticks = 18'h01388;   // 50 ms
      4'hA:    hssdc_width_ticks = 18'h01770;   // 60 ms
      4'hB:    hssdc_width_ticks = 18'h01F40;   // 80 ms
      4'hC:    hssdc_width_ticks = 18'h02710;   // 100 ms
      4'hD:    hssdc_width_ticks = 18'h03A98;   // 150 ms
      4'hE:    hssdc_width_ticks = 18'h04E20;   // 200 ms
      default: hssdc_width_ticks = 18'h00000;
    endcase
  endfunction

  // Period in 10 us ticks
  function automatic logic [17:0] hssdc_period_ticks(input logic [2:0] code);
    case (code)
      3'h0:    hssdc_period_ticks = 18'h003E8;  // 10 ms
      3'h1:    hssdc_period_ticks = 18'h007D0;  // 20 ms
      3'h2:    hssdc_period_ticks = 18'h01388;  // 50 ms
      3'h3:    hssdc_period_ticks = 18'h02710;  // 100 ms
      3'h4:    hssdc_period_ticks = 18'h04E20;  // 200 ms
      3'h5:    hssdc_period_ticks = 18'h0C350;  // 500 ms
      3'h6:    hssdc_period_ticks = 18'h186A0;  // 1000 ms
      default: hssdc_period_ticks = 18'h30D40;  // 2000 ms
    endcase
  endfunction

endpackage

// ### hssdc_properties.sv
// Port-level assertions for the high-side switch drive control block
`timescale 1ns/10ps

module hssdc_properties
  import hssdc_pkg::*;
#(
  parameter int PWM_PRESC_LO_CYC = PWM_PRESC_LO,
  parameter int PWM_PRESC_HI_CYC = PWM_PRESC_HI,
  parameter int TIMER_TICK_CYCS  = TIMER_TICK_CYC
) (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       extra_source_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       switch_on_o
);
  localparam logic [7:0] MASK [9] = '{8'hF0, 8'h80, 8'h03, 8'hFF, 8'h80, 8'h03, 8'hFF, 8'hF7, 8'hF7};
  logic [7:0] shadow      [9];
  logic [7:0] next_shadow [9];
  logic [6:0] off;
  logic [7:0] rd_exp;
  logic       dz_a;
  logic       df_b;
  logic       tw_off;
  logic       tw_full;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow register file rebuilt from write strobes only, so a stuck register shows up
  always_comb begin
    off         = reg_addr_i - ADDR_SWITCH_CONTROL;
    next_shadow = shadow;
    if (reg_wr_i && off < 7'h09) begin
      next_shadow[off[3:0]] = reg_wdata_i & MASK[off[3:0]];
    end
    rd_exp  = (off < 7'h09) ? shadow[off[3:0]] : 8'h00;
    dz_a    = shadow[0][7:4] == 4'h9 && {shadow[2][1:0], shadow[3]} == 10'h000;
    df_b    = shadow[0][7:4] == 4'hA && {shadow[5][1:0], shadow[6]} == 10'h3FF;
    tw_off  = shadow[0][7:4] == 4'hB && shadow[7][7:4] == 4'h0;
    tw_full = shadow[0][7:4] == 4'hC && shadow[8][7:4] == 4'hF;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shadow <= '{default: 8'h00};
    end else begin
      shadow <= next_shadow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // Two settled cycles allow for one extra pipeline stage inside a generator
  sequence s_rd_taken;
    reg_rd_i;
  endsequence
  sequence s_duty_zero;
    dz_a [*2];
  endsequence
  sequence s_duty_full;
    df_b [*2];
  endsequence

  a_reset_clears: assert property (disable iff (1'b0) srst_i |=> !switch_on_o && reg_rdata_o == 8'h00)
    else $error("outputs not cleared by reset");
  a_disabled_off: assert property (!$past(shadow[0][7]) |-> !switch_on_o)
    else $error("switch on while disabled");
  a_onoff_on: assert property ($past(shadow[0][7:4]) == 4'h8 |-> switch_on_o)
    else $error("plain on source not driving switch");
  a_extra_follow: assert property ($past(shadow[0][7:4]) == 4'hD |-> switch_on_o == $past(extra_source_i))
    else $error("extra source not followed");
  a_bad_src_off: assert property ($past(shadow[0][6:5]) == 2'h3 |-> !switch_on_o)
    else $error("unused source code drives switch");
  a_duty_zero_off: assert property (s_duty_zero |=> !switch_on_o)
    else $error("zero duty turned switch on");
  a_duty_full_on: assert property (s_duty_full |=> switch_on_o)
    else $error("full duty turned switch off");
  a_width_off: assert property (tw_off [*2] |=> !switch_on_o)
    else $error("zero on-width turned switch on");
  a_width_full: assert property (tw_full ##1 tw_full |=> switch_on_o)
    else $error("full on-width turned switch off");
  a_read_data: assert property (s_rd_taken |=> reg_rdata_o == $past(rd_exp))
    else $error("read data mismatch");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule

bind hssdc_top hssdc_properties #(
  .PWM_PRESC_LO_CYC(PWM_PRESC_LO_CYC),
  .PWM_PRESC_HI_CYC(PWM_PRESC_HI_CYC),
  .TIMER_TICK_CYCS (TIMER_TICK_CYCS)
) i_props (
  .clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .extra_source_i(extra_source_i), .reg_rdata_o(reg_rdata_o), .switch_on_o(switch_on_o)
);

// ### hssdc_top.sv
// High-side switch drive control: registers, duty generators, pulse timers
//
// Notes on behaviour
// RULE_01: Enable bit zero keeps switch off; one lets the selected source drive it.
// RULE_02: Source field: on/off, duty gen A, B, timer A, B, extra source.
// RULE_03: Rate bit 7 of each duty generator: zero 200 Hz, one 400 Hz.
// RULE_04: Ten-bit duty is two upper bits plus a separate lower byte.
// RULE_05: Duty code all zeros keeps the switch off the whole period.
// RULE_06: Duty code all ones keeps the switch on the whole period.
// RULE_07: Each duty increment adds about one thousandth of the period on-time.
// RULE_08: Software avoids tiny nonzero duty codes; switch edges limit on-time.
// RULE_09: Timer on-width code: 0 off, 15 on, else 0.1 to 200 ms.
// RULE_10: Timer period code selects 10 ms up to 2000 ms.
// RULE_11: Software keeps timer on-width inside the selected period.
// RULE_12: Software avoids 0.1 ms on-width when waking samples every 65 us.
// RULE_13: Timer turns switch on at each period start for the on-width.
`timescale 1ns/10ps

module hssdc_top
  import hssdc_pkg::*;
#(
  parameter int PWM_PRESC_LO_CYC = PWM_PRESC_LO,
  parameter int PWM_PRESC_HI_CYC = PWM_PRESC_HI,
  parameter int TIMER_TICK_CYCS  = TIMER_TICK_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       extra_source_i,
  output logic      [7:0] reg_rdata_o,
  output logic            switch_on_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic       switch_enable_bit;
  logic [2:0] switch_source_select;
  logic [1:0] rate_bit;
  logic [1:0] upper_bits [2];
  logic [7:0] lower_byte [2];
  logic [3:0] on_width   [2];
  logic [2:0] period_code[2];
  logic       next_switch_enable_bit;
  logic [2:0] next_switch_source_select;
  logic [1:0] next_rate_bit;
  logic [1:0] next_upper_bits [2];
  logic [7:0] next_lower_byte [2];
  logic [3:0] next_on_width   [2];
  logic [2:0] next_period_code[2];
  logic [7:0] next_reg_rdata;

  // Register writes and read mux; unmapped and reserved bits read as zero
  always_comb begin
    next_switch_enable_bit    = switch_enable_bit;
    next_switch_source_select = switch_source_select;
    next_rate_bit             = rate_bit;
    next_upper_bits           = upper_bits;
    next_lower_byte           = lower_byte;
    next_on_width             = on_width;
    next_period_code          = period_code;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_SWITCH_CONTROL: begin
          next_switch_enable_bit    = reg_wdata_i[SW_ENABLE_BIT];           // RULE_01
          next_switch_source_select = reg_wdata_i[SW_SOURCE_LSB +: 3];      // RULE_02
        end
        ADDR_DUTY_GEN_A_RATE:    next_rate_bit[0]     = reg_wdata_i[RATE_BIT];  // RULE_03
        ADDR_DUTY_GEN_B_RATE:    next_rate_bit[1]     = reg_wdata_i[RATE_BIT];  // RULE_03
        ADDR_DUTY_GEN_A_DUTY_HI: next_upper_bits[0]   = reg_wdata_i[1:0];       // RULE_04
        ADDR_DUTY_GEN_B_DUTY_HI: next_upper_bits[1]   = reg_wdata_i[1:0];       // RULE_04
        ADDR_DUTY_GEN_A_DUTY_LO: next_lower_byte[0]   = reg_wdata_i;            // RULE_04
        ADDR_DUTY_GEN_B_DUTY_LO: next_lower_byte[1]   = reg_wdata_i;            // RULE_04
        ADDR_PULSE_TIMER_A_CFG: begin
          next_on_width[0]    = reg_wdata_i[TIMER_WIDTH_LSB +: 4];
          next_period_code[0] = reg_wdata_i[TIMER_PERIOD_LSB +: 3];
        end
        ADDR_PULSE_TIMER_B_CFG: begin
          next_on_width[1]    = reg_wdata_i[TIMER_WIDTH_LSB +: 4];
          next_period_code[1] = reg_wdata_i[TIMER_PERIOD_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
    next_reg_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_SWITCH_CONTROL:     next_reg_rdata = {switch_enable_bit, switch_source_select, 4'h0};
        ADDR_DUTY_GEN_A_RATE:    next_reg_rdata = {rate_bit[0], 7'h00};
        ADDR_DUTY_GEN_B_RATE:    next_reg_rdata = {rate_bit[1], 7'h00};
        ADDR_DUTY_GEN_A_DUTY_HI: next_reg_rdata = {6'h00, upper_bits[0]};
        ADDR_DUTY_GEN_B_DUTY_HI: next_reg_rdata = {6'h00, upper_bits[1]};
        ADDR_DUTY_GEN_A_DUTY_LO: next_reg_rdata = lower_byte[0];
        ADDR_DUTY_GEN_B_DUTY_LO: next_reg_rdata = lower_byte[1];
        ADDR_PULSE_TIMER_A_CFG:  next_reg_rdata = {on_width[0], 1'b0, period_code[0]};
        ADDR_PULSE_TIMER_B_CFG:  next_reg_rdata = {on_width[1], 1'b0, period_code[1]};
        default:                 next_reg_rdata = 8'h00;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      switch_enable_bit    <= 1'b0;
      switch_source_select <= SRC_ON_OFF;
      rate_bit             <= 2'h0;
      upper_bits           <= '{2'h0, 2'h0};
      lower_byte           <= '{REG_RESET, REG_RESET};
      on_width             <= '{WIDTH_OFF, WIDTH_OFF};
      period_code          <= '{3'h0, 3'h0};
      reg_rdata_o          <= 8'h00;
    end else begin
      switch_enable_bit    <= next_switch_enable_bit;
      switch_source_select <= next_switch_source_select;
      rate_bit             <= next_rate_bit;
      upper_bits           <= next_upper_bits;
      lower_byte           <= next_lower_byte;
      on_width             <= next_on_width;
      period_code          <= next_period_code;
      reg_rdata_o          <= next_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty generators: prescaler makes one step enable, 1024 steps per period
  logic [7:0] presc_cnt     [2];
  logic [9:0] step_cnt      [2];
  logic [1:0] duty_on;
  logic [7:0] next_presc_cnt[2];
  logic [9:0] next_step_cnt [2];
  logic [9:0] duty_code;
  logic [7:0] presc_last;

  always_comb begin
    for (int g = 0; g < 2; g++) begin
      presc_last = rate_bit[g] ? 8'(PWM_PRESC_HI_CYC - 1) : 8'(PWM_PRESC_LO_CYC - 1);  // RULE_03
      duty_code  = {upper_bits[g], lower_byte[g]};                                     // RULE_04
      next_presc_cnt[g] = presc_cnt[g] + 8'h01;
      next_step_cnt[g]  = step_cnt[g];
      // Compare with >= so a rate change mid-count cannot run the prescaler away
      if (presc_cnt[g] >= presc_last) begin
        next_presc_cnt[g] = 8'h00;
        next_step_cnt[g]  = step_cnt[g] + 10'h001;
      end
      if (duty_code == 10'h3FF) begin
        duty_on[g] = 1'b1;                        // RULE_06
      end else begin
        duty_on[g] = step_cnt[g] < duty_code;     // RULE_05 RULE_07
      end
    end
  end

  // Duty generator flops; generators run free so a source switch lands mid-period
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      presc_cnt <= '{8'h00, 8'h00};
      step_cnt  <= '{10'h000, 10'h000};
    end else begin
      presc_cnt <= next_presc_cnt;
      step_cnt  <= next_step_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse timers: shared 10 us tick, per-timer tick counter within the period
  logic [7:0]  tick_cnt;
  logic        tick;
  logic [7:0]  next_tick_cnt;
  logic [17:0] tmr_cnt      [2];
  logic [17:0] next_tmr_cnt [2];
  logic [1:0]  tmr_on;
  logic [2:0]  tmr_src;

  always_comb begin
    tick          = tick_cnt == 8'(TIMER_TICK_CYCS - 1);
    next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
    for (int t = 0; t < 2; t++) begin
      tmr_src         = (t == 0) ? SRC_TIMER_A : SRC_TIMER_B;
      next_tmr_cnt[t] = tmr_cnt[t];
      // Held at period start while not selected so each selection opens on-phase
      if (switch_source_select != tmr_src) begin
        next_tmr_cnt[t] = 18'h00000;                                          // RULE_13
      end else if (tick) begin
        if (tmr_cnt[t] >= hssdc_period_ticks(period_code[t]) - 18'h00001) begin
          next_tmr_cnt[t] = 18'h00000;                                        // RULE_10
        end else begin
          next_tmr_cnt[t] = tmr_cnt[t] + 18'h00001;
        end
      end
      // Width past the period just stays on; software keeps it inside
      if (on_width[t] == WIDTH_FULL) begin
        tmr_on[t] = 1'b1;                                                     // RULE_09
      end else begin
        tmr_on[t] = tmr_cnt[t] < hssdc_width_ticks(on_width[t]);              // RULE_09 RULE_13
      end
    end
  end

  // Timer flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_cnt <= 8'h00;
      tmr_cnt  <= '{18'h00000, 18'h00000};
    end else begin
      tick_cnt <= next_tick_cnt;
      tmr_cnt  <= next_tmr_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch source mux and enable gate
  logic next_switch_on;

  always_comb begin
    case (switch_source_select)                               // RULE_02
      SRC_ON_OFF:     next_switch_on = 1'b1;
      SRC_DUTY_GEN_A: next_switch_on = duty_on[0];
      SRC_DUTY_GEN_B: next_switch_on = duty_on[1];
      SRC_TIMER_A:    next_switch_on = tmr_on[0];
      SRC_TIMER_B:    next_switch_on = tmr_on[1];
      SRC_EXTRA:      next_switch_on = extra_source_i;
      default:        next_switch_on = 1'b0;                  // Unused codes keep it off
    endcase
    next_switch_on = next_switch_on & switch_enable_bit;      // RULE_01
  end

  // Output flop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      switch_on_o <= 1'b0;
    end else begin
      switch_on_o <= next_switch_on;
    end
  end

endmodule

// ### hssdc_top_test.sv
// Self-checking bench for the high-side switch drive control block
`timescale 1ns/10ps

module hssdc_top_test;
  import hssdc_pkg::*;
  // Short counts keep the run brief; expectations scale from them
  localparam int PLO = 4;
  localparam int PHI = 2;
  localparam int TCK = 2;
  localparam logic [7:0] MASK [10] = '{8'hF0, 8'h80, 8'h03, 8'hFF, 8'h80, 8'h03, 8'hFF, 8'hF7, 8'hF7, 8'h00};
  localparam logic [7:0] SETUP [7] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'hFF, 8'h00, 8'hF0};
  localparam int WID [15] = '{0, 1, 3, 5, 10, 100, 200, 300, 400, 500, 600, 800, 1000, 1500, 2000};
  localparam int PER [8]  = '{10, 20, 50, 100, 200, 500, 1000, 2000};
  logic       clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [6:0] reg_addr_i = 7'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       extra_source_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       switch_on_o;
  logic [7:0] rnd = 8'h0C;
  logic [7:0] rd_val;
  logic [9:0] duty;
  logic [6:0] base;
  int         on_len;
  int         period;
  int         rises;
  int         p;
  int         err_count = 0;
  int         compares = 0;

  initial forever #20 clk_i = ~clk_i;

  hssdc_top #(.PWM_PRESC_LO_CYC(PLO), .PWM_PRESC_HI_CYC(PHI), .TIMER_TICK_CYCS(TCK)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .extra_source_i(extra_source_i), .reg_rdata_o(reg_rdata_o), .switch_on_o(switch_on_o));
  hssdc_load_model i_load (.clk_i(clk_i), .srst_i(srst_i), .switch_on_i(switch_on_o), .on_len_o(on_len),
    .period_o(period), .rises_o(rises));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Level per source with duty A zero, duty B full, timer A width 0, timer B width 15
  function automatic logic exp_sw(input logic en, input logic [2:0] src, input logic ex);
    logic [7:0] lvl;
    lvl = {2'h0, ex, 5'h15};
    return en & lvl[src];
  endfunction

  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      err_count++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a);
    @(negedge clk_i);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    rd_val   = reg_rdata_o;
  endtask
  // The third turn-on edge closes a period run entirely on the new settings
  task automatic measure(input int exp_on, input int exp_per);
    int r0;
    int n;
    r0 = rises;
    n  = 0;
    while (rises < r0 + 3 && n < 5 * exp_per) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 5 * exp_per) begin
      err_count++;
      $display("[ERR] %0t no pulses on the switch", $time);
      conclude();
    end
    chk_n(on_len, exp_on);
    chk_n(period, exp_per);
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk_i);
    srst_i = 1'b0;
    // Reset values, then random writes read back with reserved bits at zero; 27h is unmapped
    for (int i = 0; i < 10; i++) begin
      rd(7'h1E + 7'(i));
      chk_v(rd_val, 8'h00);
      rnd = lfsr(rnd);
      wr(7'h1E + 7'(i), rnd);
      rd(7'h1E + 7'(i));
      chk_v(rd_val, rnd & MASK[i]);
    end
    // Every source code with the enable off and on
    for (int i = 0; i < 7; i++) begin
      wr(7'h20 + 7'(i), SETUP[i]);
    end
    for (int k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      extra_source_i = rnd[0];
      wr(7'h1E, {k[0], k[3:1], 4'h0});
      repeat (4) @(negedge clk_i);
      chk_v({7'h00, switch_on_o}, {7'h00, exp_sw(k[0], k[3:1], rnd[0])});
    end
    // Both generators at both rates; codes stay clear of the switch's edge times, one below full as corner
    for (int k = 0; k < 4; k++) begin
      rnd  = lfsr(rnd);
      duty = (k == 0) ? 10'h040 : (k == 3) ? 10'h3FE : ({1'b0, rnd[0], rnd} | 10'h040);
      base = k[1] ? ADDR_DUTY_GEN_B_RATE : ADDR_DUTY_GEN_A_RATE;
      p    = k[0] ? PHI : PLO;
      wr(base, {k[0], 7'h00});
      wr(base + 7'h01, {6'h00, duty[9:8]});
      wr(base + 7'h02, duty[7:0]);
      wr(7'h1E, {2'h2, k[1], !k[1], 4'h0});
      measure(int'(duty) * p, 1024 * p);
    end
    // Timer pulses measured against the coded width and period; widths fit the period, no 0.1 ms code
    wr(7'h25, 8'h20);
    wr(7'h1E, 8'hB0);
    measure(WID[2] * 10 * TCK, PER[0] * 100 * TCK);
    wr(7'h26, 8'h41);
    wr(7'h1E, 8'hC0);
    measure(WID[4] * 10 * TCK, PER[1] * 100 * TCK);
    // Reset in mid-run while the switch is active
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_v({7'h00, switch_on_o}, 8'h00);
    srst_i = 1'b0;
    rd(7'h1E);
    chk_v(rd_val, 8'h00);
    conclude();
  end
endmodule
